// file: verilog/quad_serial_host_port.sv
// serial host port: spi mode 0 slave with single, dual and quad lanes
`timescale 1ns/100ps
module quad_serial_host_port (
   input wire logic clk_i,
   input wire logic rst_n_i,
   // host pins
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic reset_powerdown_n_i,
   input wire logic io0_i,
   output logic io0_o,
   output logic io0_oe_o,
   input wire logic io1_i,
   output logic io1_o,
   output logic io1_oe_o,
   input wire logic io2_i,
   output logic io2_o,
   output logic io2_oe_o,
   input wire logic io3_i,
   output logic io3_o,
   output logic io3_oe_o,
   output logic int_n_o,
   // core side
   input wire logic irq_i,
   output logic [7:0] rx_data_o,
   output logic rx_valid_o,
   input wire logic [7:0] tx_data_i,
   input wire logic tx_load_i,
   output logic tx_next_o,
   input wire logic [1:0] gpio_out_i,
   input wire logic [1:0] gpio_oe_i,
   output logic [1:0] gpio_in_o,
   output logic [1:0] lane_width_o,
   output logic powerdown_o
);
   // ---------------- link domain (sclk_i) ----------------
   quad_serial_host_port_pkg::phase_t phase_reg, phase_next;
   logic [2:0] cnt_reg, cnt_next;
   logic [7:0] sr_reg, sr_next;
   logic [7:0] out_sr_reg, out_sr_next;
   logic [3:0] io_out_reg, io_out_next;
   logic [3:0] io_oe_reg, io_oe_next;
   logic rx_tog_reg, rx_tog_next;
   logic rx_kind_reg, rx_kind_next;
   logic [7:0] rx_byte_reg, rx_byte_next;
   logic tx_tog_reg, tx_tog_next;
   logic [1:0] width_s;
   logic [7:0] tx_word_s;
   logic [3:0] lanes;
   logic [3:0] bpe;
   logic [3:0] cnt_sum;
   logic [7:0] shifted;
   logic byte_done;
   logic deliver;
   logic frame_clr;

   // ---------------- core domain (clk_i) ----------------
   logic [1:0] width_reg, width_next;
   logic rx_seen_reg, rx_seen_next;
   logic rx_hit_reg, rx_hit_next;
   logic rx_valid_reg, rx_valid_next;
   logic [7:0] rx_data_reg, rx_data_next;
   logic [7:0] tx_word_reg, tx_word_next;
   logic tx_seen_reg, tx_seen_next;
   logic tx_next_reg, tx_next_next;
   logic int_n_reg, int_n_next;
   logic [1:0] gpio_out_reg, gpio_out_next;
   logic [1:0] gpio_oe_reg, gpio_oe_next;
   logic powerdown_reg, powerdown_next;
   logic rpd_s;
   logic [1:0] gpio_s;
   logic rx_tog_s, rx_kind_s;
   logic [7:0] rx_byte_s;
   logic tx_tog_s;
   logic dev_rst_n;
   logic quad_on;

   // width and transmit word cross into the link clock as quasi-static words
   cdc_sync #(.W(10)) link_sync (
      .clk_i(sclk_i),
      .rst_n_i(1'h1),
      .d_i({width_reg, tx_word_reg}),
      .q_o({width_s, tx_word_s})
   );

   // pins and link toggles cross into the core clock
   cdc_sync #(.W(14)) core_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .d_i({reset_powerdown_n_i, io3_i, io2_i, rx_tog_reg, rx_kind_reg,
         rx_byte_reg, tx_tog_reg}),
      .q_o({rpd_s, gpio_s, rx_tog_s, rx_kind_s, rx_byte_s, tx_tog_s})
   );

   // frame state is wiped whenever chip select is high or reset_powerdown_n_i is low
   assign frame_clr = cs_n_i | ~reset_powerdown_n_i;

   // bits per edge for the configured width
   always_comb begin
      case (width_s)
         quad_serial_host_port_pkg::WIDTH_DUAL:
            bpe = quad_serial_host_port_pkg::LANES_DUAL;
         quad_serial_host_port_pkg::WIDTH_QUAD:
            bpe = quad_serial_host_port_pkg::LANES_QUAD;
         default:
            bpe = quad_serial_host_port_pkg::LANES_SINGLE;
      endcase
   end

   // sample on the rising edge: command byte single lane, payload at width
   always_comb begin
      phase_next = phase_reg;
      sr_next = sr_reg;
      deliver = 1'h0;
      lanes = (phase_reg == quad_serial_host_port_pkg::PH_CMD) ?
         quad_serial_host_port_pkg::LANES_SINGLE : bpe;
      case (lanes)
         quad_serial_host_port_pkg::LANES_DUAL:
            shifted = {sr_reg[5:0], io1_i, io0_i};
         quad_serial_host_port_pkg::LANES_QUAD:
            shifted = {sr_reg[3:0], io3_i, io2_i, io1_i, io0_i};
         default:
            shifted = {sr_reg[6:0], io0_i};
      endcase
      cnt_sum = {1'h0, cnt_reg} + lanes;
      byte_done = (cnt_sum == quad_serial_host_port_pkg::BITS_PER_BYTE);
      cnt_next = byte_done ? quad_serial_host_port_pkg::COUNT_RESET :
         cnt_sum[2:0];
      sr_next = shifted;
      if (byte_done) begin
         case (phase_reg)
            quad_serial_host_port_pkg::PH_CMD: begin
               case (shifted)
                  quad_serial_host_port_pkg::CMD_SET_WIDTH:
                     phase_next = quad_serial_host_port_pkg::PH_SETW;
                  quad_serial_host_port_pkg::CMD_WRITE:
                     phase_next = quad_serial_host_port_pkg::PH_WRITE;
                  quad_serial_host_port_pkg::CMD_READ:
                     phase_next = quad_serial_host_port_pkg::PH_READ;
                  default:
                     phase_next = quad_serial_host_port_pkg::PH_SKIP;
               endcase
            end
            quad_serial_host_port_pkg::PH_SETW: begin
               deliver = 1'h1;
               phase_next = quad_serial_host_port_pkg::PH_SKIP;
            end
            quad_serial_host_port_pkg::PH_WRITE: begin
               deliver = 1'h1;
            end
            default: begin
               phase_next = phase_reg;
            end
         endcase
      end
   end

   // mode 0 samples on the rising edge; sclk clocks it directly
   always_ff @(posedge sclk_i or posedge frame_clr) begin
      if (frame_clr) begin
         phase_reg <= quad_serial_host_port_pkg::PH_CMD;
         cnt_reg <= quad_serial_host_port_pkg::COUNT_RESET;
         sr_reg <= quad_serial_host_port_pkg::BYTE_RESET;
      end else begin
         phase_reg <= phase_next;
         cnt_reg <= cnt_next;
         sr_reg <= sr_next;
      end
   end

   // received byte and its toggle survive the frame; kind 1 means width
   always_comb begin
      rx_tog_next = rx_tog_reg ^ deliver;
      rx_byte_next = deliver ? shifted : rx_byte_reg;
      rx_kind_next = deliver ?
         (phase_reg == quad_serial_host_port_pkg::PH_SETW) : rx_kind_reg;
   end

   always_ff @(posedge sclk_i or negedge reset_powerdown_n_i) begin
      if (!reset_powerdown_n_i) begin
         rx_tog_reg <= 1'h0;
         rx_kind_reg <= 1'h0;
         rx_byte_reg <= quad_serial_host_port_pkg::BYTE_RESET;
      end else begin
         rx_tog_reg <= rx_tog_next;
         rx_kind_reg <= rx_kind_next;
         rx_byte_reg <= rx_byte_next;
      end
   end

   // falling edge drives data so it is stable at the next rising edge
   always_comb begin
      out_sr_next = out_sr_reg;
      tx_tog_next = tx_tog_reg;
      if (phase_reg == quad_serial_host_port_pkg::PH_READ) begin
         if (cnt_reg == quad_serial_host_port_pkg::COUNT_RESET) begin
            out_sr_next = tx_word_s;
            tx_tog_next = ~tx_tog_reg;
         end else begin
            out_sr_next = out_sr_reg << bpe;
         end
      end
      io_out_next = 4'h0;
      io_oe_next = quad_serial_host_port_pkg::OE_NONE;
      case (width_s)
         quad_serial_host_port_pkg::WIDTH_DUAL: begin
            io_out_next = {2'h0, out_sr_next[7:6]};
            if (phase_reg == quad_serial_host_port_pkg::PH_READ) begin
               io_oe_next = quad_serial_host_port_pkg::OE_DUAL;
            end
         end
         quad_serial_host_port_pkg::WIDTH_QUAD: begin
            io_out_next = out_sr_next[7:4];
            if (phase_reg == quad_serial_host_port_pkg::PH_READ) begin
               io_oe_next = quad_serial_host_port_pkg::OE_QUAD;
            end
         end
         default: begin
            // single lane: line 1 is always an output while selected
            io_out_next = {2'h0, out_sr_next[7], 1'h0};
            io_oe_next = quad_serial_host_port_pkg::OE_SINGLE;
         end
      endcase
      if (phase_reg != quad_serial_host_port_pkg::PH_READ) begin
         io_out_next = 4'h0;
      end
   end

   always_ff @(negedge sclk_i or posedge frame_clr) begin
      if (frame_clr) begin
         out_sr_reg <= quad_serial_host_port_pkg::BYTE_RESET;
         io_out_reg <= 4'h0;
         io_oe_reg <= quad_serial_host_port_pkg::OE_NONE;
      end else begin
         out_sr_reg <= out_sr_next;
         io_out_reg <= io_out_next;
         io_oe_reg <= io_oe_next;
      end
   end

   always_ff @(negedge sclk_i or negedge reset_powerdown_n_i) begin
      if (!reset_powerdown_n_i) begin
         tx_tog_reg <= 1'h0;
      end else begin
         tx_tog_reg <= tx_tog_next;
      end
   end

   // core reset: own reset or the host pin, both hold width at single
   assign dev_rst_n = rst_n_i & rpd_s;

   // core side: width update, byte hand-off, transmit word, pins
   always_comb begin
      width_next = width_reg;
      rx_seen_next = rx_tog_s;
      rx_hit_next = 1'h0;
      rx_valid_next = 1'h0;
      rx_data_next = rx_data_reg;
      tx_seen_next = tx_tog_s;
      tx_next_next = tx_tog_s ^ tx_seen_reg;
      tx_word_next = tx_load_i ? tx_data_i : tx_word_reg;
      int_n_next = ~irq_i;
      gpio_out_next = gpio_out_i;
      gpio_oe_next = gpio_oe_i;
      powerdown_next = ~rpd_s;
      // act one cycle after the toggle flips, so every byte bit has settled
      rx_hit_next = (rx_tog_s != rx_seen_reg);
      if (rx_hit_reg) begin
         if (rx_kind_s) begin
            // the reserved code leaves the width as it was
            if (rx_byte_s[1:0] != 2'h3) begin
               width_next = rx_byte_s[1:0];
            end
         end else begin
            rx_valid_next = 1'h1;
            rx_data_next = rx_byte_s;
         end
      end
      if (!dev_rst_n) begin
         width_next = quad_serial_host_port_pkg::WIDTH_RESET;
         rx_seen_next = rx_tog_s;
         rx_hit_next = 1'h0;
         rx_valid_next = 1'h0;
         rx_data_next = quad_serial_host_port_pkg::BYTE_RESET;
         tx_seen_next = tx_tog_s;
         tx_next_next = 1'h0;
         tx_word_next = quad_serial_host_port_pkg::BYTE_RESET;
         int_n_next = 1'h1;
         gpio_out_next = 2'h0;
         gpio_oe_next = 2'h0;
      end
   end

   always_ff @(posedge clk_i) begin
      width_reg <= width_next;
      rx_seen_reg <= rx_seen_next;
      rx_hit_reg <= rx_hit_next;
      rx_valid_reg <= rx_valid_next;
      rx_data_reg <= rx_data_next;
      tx_seen_reg <= tx_seen_next;
      tx_next_reg <= tx_next_next;
      tx_word_reg <= tx_word_next;
      int_n_reg <= int_n_next;
      gpio_out_reg <= gpio_out_next;
      gpio_oe_reg <= gpio_oe_next;
      powerdown_reg <= powerdown_next;
   end

   // the shared pins pick link or gpio flops by width; only a mux between
   assign quad_on = (width_reg == quad_serial_host_port_pkg::WIDTH_QUAD);
   assign io0_o = io_out_reg[0];
   assign io0_oe_o = io_oe_reg[0];
   assign io1_o = io_out_reg[1];
   assign io1_oe_o = io_oe_reg[1];
   assign io2_o = quad_on ? io_out_reg[2] : gpio_out_reg[0];
   assign io2_oe_o = quad_on ? io_oe_reg[2] : gpio_oe_reg[0];
   assign io3_o = quad_on ? io_out_reg[3] : gpio_out_reg[1];
   assign io3_oe_o = quad_on ? io_oe_reg[3] : gpio_oe_reg[1];
   assign int_n_o = int_n_reg;
   assign rx_data_o = rx_data_reg;
   assign rx_valid_o = rx_valid_reg;
   assign tx_next_o = tx_next_reg;
   assign gpio_in_o = gpio_s;
   assign lane_width_o = width_reg;
   assign powerdown_o = powerdown_reg;
endmodule

// file: verilog/quad_serial_host_port_pkg.sv
// constants, encodings and phase type of the quad serial host port
// How it works
// - serial link runs clock polarity 0, phase 0 only, in every lane width
// - serial clock up to 30 MHz, period never below 33.3 ns
// - after reset the port is single lane, data in on line 0, out on line 1
// - one slave offers single, dual and quad widths as a configuration
// - in dual and quad, lines 0 and 1 become two-way data lines
// - two pins are gpio in single and dual, data lines 2 and 3 in quad
// - interrupt output is active low and idles high
package quad_serial_host_port_pkg;
   // lane width encodings held in the width setting
   localparam logic [1:0] WIDTH_SINGLE = 2'h0;
   localparam logic [1:0] WIDTH_DUAL = 2'h1;
   localparam logic [1:0] WIDTH_QUAD = 2'h2;
   localparam logic [1:0] WIDTH_RESET = WIDTH_SINGLE;
   // command bytes, always sent on a single lane
   localparam logic [7:0] CMD_SET_WIDTH = 8'hb0;
   localparam logic [7:0] CMD_WRITE = 8'h02;
   localparam logic [7:0] CMD_READ = 8'h0b;
   // bits moved per serial clock edge and bits in a byte
   localparam logic [3:0] LANES_SINGLE = 4'h1;
   localparam logic [3:0] LANES_DUAL = 4'h2;
   localparam logic [3:0] LANES_QUAD = 4'h4;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   // output enable patterns for lines 3..0
   localparam logic [3:0] OE_NONE = 4'h0;
   localparam logic [3:0] OE_SINGLE = 4'h2;
   localparam logic [3:0] OE_DUAL = 4'h3;
   localparam logic [3:0] OE_QUAD = 4'hf;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [2:0] COUNT_RESET = 3'h0;
   // serial clock limit against the core clock
   localparam int SCLK_MAX_KHZ = 30000;
   localparam int SCLK_MIN_PERIOD_PS = 33300;
   localparam int CLK_PERIOD_PS = 40000;
   localparam int SCLK_MIN_PERIOD_CLKS =
      (SCLK_MIN_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // frame phase, gray order; command -> write or set width flips one bit, command -> read two
   typedef enum logic [2:0] {
      PH_CMD = 3'h0,
      PH_WRITE = 3'h1,
      PH_READ = 3'h3,
      PH_SETW = 3'h2,
      PH_SKIP = 3'h6
   } phase_t;
endpackage

// file: verilog/cdc_sync.sv
// two flip-flop synchroniser for levels and quasi-static words
`timescale 1ns/100ps
module cdc_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] q_next;

   // first stage feeds only the second stage
   always_comb begin
      meta_next = rst_n_i ? d_i : '0;
      q_next = rst_n_i ? meta_reg : '0;
   end

   always_ff @(posedge clk_i) begin
      meta_reg <= meta_next;
      q_o <= q_next;
   end
endmodule

// file: verif/quad_serial_host_port_asserts.sv
// concurrent checks on the serial host port pins and core side
`timescale 1ns/100ps
module quad_serial_host_port_asserts (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic cs_n_i,
   input wire logic reset_powerdown_n_i,
   input wire logic io0_oe_o,
   input wire logic io1_oe_o,
   input wire logic io2_i,
   input wire logic io3_i,
   input wire logic int_n_o,
   input wire logic irq_i,
   input wire logic rx_valid_o,
   input wire logic tx_next_o,
   input wire logic [1:0] gpio_in_o,
   input wire logic [1:0] lane_width_o,
   input wire logic powerdown_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // line drivers: lines 0 and 1 undriven outside a frame, line 0 stays an input in single
   chk_idle_oe: assert property (cs_n_i |-> !io0_oe_o && !io1_oe_o)
      else $error("data line driven with chip select high");
   chk_single_in: assert property (!cs_n_i &&
      lane_width_o == quad_serial_host_port_pkg::WIDTH_SINGLE |-> !io0_oe_o)
      else $error("line 0 driven in single lane mode");
   // interrupt pin follows the request one clock later, low active
   chk_int_follow: assert property ($past(rst_n_i) && !powerdown_o
      |-> int_n_o == !$past(irq_i))
      else $error("interrupt output not following request");
   // strobes last one cycle; reserved width code never shows
   chk_rx_pulse: assert property (rx_valid_o |=> !rx_valid_o)
      else $error("receive strobe longer than one cycle");
   chk_next_pulse: assert property (tx_next_o |=> !tx_next_o)
      else $error("transmit take strobe longer than one cycle");
   chk_width_code: assert property (lane_width_o != 2'h3)
      else $error("reserved lane width reported");
   // power-down pin: width falls back to single, status tracks the pin
   chk_pd_width: assert property (!reset_powerdown_n_i [*5] |->
      powerdown_o && lane_width_o == quad_serial_host_port_pkg::WIDTH_RESET)
      else $error("power-down did not reset width");
   chk_pd_off: assert property (reset_powerdown_n_i [*6] |-> !powerdown_o)
      else $error("power-down status without pin low");
   // gpio inputs pass two flops whatever the width
   chk_gpio_in: assert property ($past(rst_n_i) && $past(rst_n_i, 2) |->
      gpio_in_o == $past({io3_i, io2_i}, 2))
      else $error("gpio input not two cycles behind pins");
   cov_write: cover property (rx_valid_o);
   cov_read: cover property (tx_next_o);
   cov_quad: cover property (!cs_n_i && lane_width_o == 2'h2);
   cov_pd: cover property (powerdown_o);
endmodule
bind quad_serial_host_port quad_serial_host_port_asserts
   quad_serial_host_port_asserts_i (.clk_i, .rst_n_i, .cs_n_i,
   .reset_powerdown_n_i, .io0_oe_o, .io1_oe_o, .io2_i, .io3_i, .int_n_o,
   .irq_i, .rx_valid_o, .tx_next_o, .gpio_in_o, .lane_width_o,
   .powerdown_o);

// file: verif/spi_host_model.sv
// host serial master model: mode 0 clock, single, dual or quad lanes
`timescale 1ns/100ps
module spi_host_model #(
   parameter realtime HALF = 62.5 // 125 ns period, well above the limit
) (
   output logic sclk_o,
   output logic cs_n_o,
   output logic [3:0] io_o,
   input wire logic [3:0] io_i
);
   // clock rests low outside frames, chip select high
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      io_o = 4'h5;
   end
   // chip select edge with one clock period of gap after it
   task automatic frame(input logic on);
      #(HALF);
      cs_n_o = !on;
      #(2 * HALF);
   endtask
   // data set while clock low, read back just before it rises
   task automatic xfer(input logic [7:0] tx, input int l, input logic rd,
         output logic [7:0] rx);
      rx = 8'h00;
      for (int s = 0; s < 8 / l; s++) begin
         if (rd)
            io_o = ~io_o; // released lines never hold a stale level
         for (int b = 0; b < l; b++) begin
            if (!rd)
               io_o[l - 1 - b] = tx[7 - s * l - b];
         end
         #(HALF);
         for (int b = 0; b < l; b++)
            rx[7 - s * l - b] = io_i[(l == 1) ? 1 : l - 1 - b];
         sclk_o = 1'b1;
         #(HALF);
         sclk_o = 1'b0;
      end
   endtask
   // hold the lines at a level between frames
   task automatic park(input logic [3:0] v);
      io_o = v;
   endtask
endmodule

// file: verif/quad_serial_host_port_tb.sv
// self-checking bench for the serial host port
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin \
   $display("ERROR %0t: got %h expected %h", $time, a, e); \
   n_errors++; end end
module quad_serial_host_port_tb;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic pd_n = 1'b1;
   logic irq = 1'b0;
   logic tx_load = 1'b0;
   logic [7:0] tx_data = 8'hc6;
   logic [1:0] gpio_out = 2'h0;
   logic [1:0] gpio_oe = 2'h0;
   logic [1:0] cur = 2'h0;
   logic sclk, cs_n, int_n, rx_valid, tx_next, pd;
   logic [3:0] host_io, io_w, dev_o, dev_oe;
   logic [7:0] rx_data, r, rx_last;
   logic [1:0] gpio_in, width;
   int n_errors = 0;
   int n_tests = 0;
   int rx_cnt = 0;
   int tx_cnt = 0;
   int n0;
   // rows: {width sent, width expected, write byte}
   logic [11:0] rows [5] = '{12'h0a5, 12'h53c, 12'hdc3, 12'ha96, 12'h05a};
   // a line shows the device while it drives, else the host
   assign io_w = (dev_oe & dev_o) | (~dev_oe & host_io);
   quad_serial_host_port quad_serial_host_port_i (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
      .reset_powerdown_n_i(pd_n), .io0_i(io_w[0]), .io0_o(dev_o[0]),
      .io0_oe_o(dev_oe[0]), .io1_i(io_w[1]), .io1_o(dev_o[1]),
      .io1_oe_o(dev_oe[1]), .io2_i(io_w[2]), .io2_o(dev_o[2]),
      .io2_oe_o(dev_oe[2]), .io3_i(io_w[3]), .io3_o(dev_o[3]),
      .io3_oe_o(dev_oe[3]), .int_n_o(int_n), .irq_i(irq),
      .rx_data_o(rx_data), .rx_valid_o(rx_valid), .tx_data_i(tx_data),
      .tx_load_i(tx_load), .tx_next_o(tx_next), .gpio_out_i(gpio_out),
      .gpio_oe_i(gpio_oe), .gpio_in_o(gpio_in), .lane_width_o(width),
      .powerdown_o(pd));
   spi_host_model spi_host_model_i (.sclk_o(sclk), .cs_n_o(cs_n),
      .io_o(host_io), .io_i(io_w));
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   // log received bytes; hand the next word over on each take
   always @(negedge clk_i) begin
      if (rx_valid === 1'b1) begin
         rx_cnt++;
         rx_last = rx_data;
      end
      if (tx_next === 1'b1) begin
         tx_data <= ~tx_data; // c6 and 39 take turns
         tx_cnt++;
      end
   end
   function automatic int lanes(input logic [1:0] w);
      return (w == 2'h2) ? 4 : (w == 2'h1) ? 2 : 1;
   endfunction
   // one frame: command on one lane, then one payload byte
   task automatic wr(input logic [7:0] c, input logic [7:0] d, input int l);
      @(negedge clk_i);
      #1; // keeps host edges off core clock edges
      spi_host_model_i.frame(1'b1);
      spi_host_model_i.xfer(c, 1, 1'b0, r);
      spi_host_model_i.xfer(d, l, 1'b0, r);
      spi_host_model_i.frame(1'b0);
      repeat (6) @(negedge clk_i);
   endtask
   task automatic pd_pulse;
      pd_n = 1'b0;
      repeat (6) @(negedge clk_i);
      `CHK(pd, 1'b1)
      `CHK(width, quad_serial_host_port_pkg::WIDTH_RESET)
      pd_n = 1'b1;
      cur = 2'h0;
      repeat (6) @(negedge clk_i);
      `CHK(pd, 1'b0)
   endtask
   task automatic results;
      if (n_errors == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (20) @(negedge clk_i);
      rst_n_i = 1'b1;
      repeat (4) @(negedge clk_i);
      `CHK(int_n, 1'b1)
      `CHK(width, quad_serial_host_port_pkg::WIDTH_SINGLE)
      pd_pulse();
      irq = 1'b1;
      repeat (2) @(negedge clk_i);
      `CHK(int_n, 1'b0)
      irq = 1'b0;
      repeat (2) @(negedge clk_i);
      `CHK(int_n, 1'b1)
      spi_host_model_i.park(4'h8);
      repeat (4) @(negedge clk_i);
      `CHK(gpio_in, 2'h2)
      gpio_oe = 2'h3;
      gpio_out = 2'h1;
      repeat (4) @(negedge clk_i);
      `CHK(gpio_in, 2'h1)
      // width is changed through the port, then a byte is written
      for (int i = 0; i < 5; i++) begin
         wr(quad_serial_host_port_pkg::CMD_SET_WIDTH,
            {6'h00, rows[i][11:10]}, lanes(cur));
         cur = rows[i][9:8];
         `CHK(width, cur)
         n0 = rx_cnt;
         wr(quad_serial_host_port_pkg::CMD_WRITE, rows[i][7:0], lanes(cur));
         `CHK(rx_cnt, n0 + 1)
         `CHK(rx_last, rows[i][7:0])
      end
      // clocking with chip select high, then an unknown command
      n0 = rx_cnt;
      #1;
      spi_host_model_i.xfer(quad_serial_host_port_pkg::CMD_WRITE, 1, 1'b0, r);
      spi_host_model_i.xfer(8'h44, 1, 1'b0, r);
      wr(8'h77, 8'h11, 1);
      `CHK(rx_cnt, n0)
      // two byte read on line 1 with the core reloading between bytes
      tx_load = 1'b1;
      @(negedge clk_i);
      #1;
      spi_host_model_i.frame(1'b1);
      spi_host_model_i.xfer(quad_serial_host_port_pkg::CMD_READ, 1, 1'b0, r);
      spi_host_model_i.xfer(8'h00, 1, 1'b1, r);
      `CHK(r, 8'hc6)
      spi_host_model_i.xfer(8'h00, 1, 1'b1, r);
      `CHK(r, 8'h39)
      spi_host_model_i.frame(1'b0);
      `CHK(tx_cnt >= 2, 1'b1)
      // dual read: lines 0 and 1 turn round, two bytes with a reload
      wr(quad_serial_host_port_pkg::CMD_SET_WIDTH, 8'h01, 1);
      `CHK(width, quad_serial_host_port_pkg::WIDTH_DUAL)
      @(negedge clk_i);
      #1;
      spi_host_model_i.frame(1'b1);
      spi_host_model_i.xfer(quad_serial_host_port_pkg::CMD_READ, 1, 1'b0, r);
      spi_host_model_i.xfer(8'h00, 2, 1'b1, r);
      `CHK(r, 8'h39)
      spi_host_model_i.xfer(8'h00, 2, 1'b1, r);
      `CHK(r, 8'hc6)
      spi_host_model_i.frame(1'b0);
      // quad width and a quad read, then power-down brings back single lane
      wr(quad_serial_host_port_pkg::CMD_SET_WIDTH, 8'h02, 2);
      `CHK(width, quad_serial_host_port_pkg::WIDTH_QUAD)
      @(negedge clk_i);
      #1;
      spi_host_model_i.frame(1'b1);
      spi_host_model_i.xfer(quad_serial_host_port_pkg::CMD_READ, 1, 1'b0, r);
      spi_host_model_i.xfer(8'h00, 4, 1'b1, r);
      `CHK(r, 8'hc6)
      spi_host_model_i.frame(1'b0);
      pd_pulse();
      results();
   end
   // cuts a hang short well past the expected run of about 40 us
   initial begin
      #200000;
      n_errors++;
      results();
   end
endmodule
